// ==== hdl/origin_return_sequencer.v ====
// Purpose: Origin return sequencer for one pulse-train axis
// Assumes: Pulse generator on core_clk reports ramp_stopped
// Notes: APB slave, one wait state on every access
// Behaviour
// - Four-bit method field selects methods 0 to 5
// - Method 0 stops on origin, by speed
// - Method 0 clears counter at origin on
// - Method 1 reverses at constant speed until origin off
// - Method 1 returns at search speed, stops on origin
// - Method 1 clears counter at origin on
// - Method 2 constant: count zero pulses, stop instantly
// - Method 2 high: decelerate while counting, stop instantly
// - Method 2 clears counter at count end
// - Method 3 constant: count then stop instantly
// - Method 3 high: count, then decelerate stop
// - Methods 3 to 5 clear counter at count end
// - Method 4 stops, reverses at search speed
// - Method 4 counts after origin off, stops instantly
// - Method 5 stops, reverses, then counts
// - Method 5 final stop instant or decelerating
// - Count field holds count minus one, 0-15
// - Start codes run until completion condition met
`timescale 1ns/1ps
`include "origin_return_defs.vh"

module origin_return_sequencer (
	input wire core_clk,
	input wire resetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire origin_sensor,
	input wire encoder_zero_pulse,
	input wire ramp_stopped,
	output reg drive_run_r,
	output reg drive_dir_r,
	output reg [1:0] speed_sel_r,
	output reg decel_r,
	output reg counter_clear_r,
	output reg done_r
);

// Sequencer states
localparam ST_IDLE = 3'd0;
localparam ST_FEED = 3'd1;
localparam ST_HALT = 3'd2;
localparam ST_REV = 3'd3;
localparam ST_SEARCH = 3'd4;
localparam ST_COUNT = 3'd5;
localparam ST_FINAL = 3'd6;

reg [7:0] env_r;
reg [2:0] state_r;
reg high_speed_r;
reg start_dir_r;
reg [3:0] zcnt_r;
reg bad_cmd_r;
reg org_d_r;
reg ez_d_r;
wire org_lvl;
wire ez_lvl;
wire org_rise;
wire org_fall;
wire ez_rise;
wire [3:0] method;
wire [3:0] zcount_target;
wire bus_take;
wire wr_take;
wire [`ADDR_W-1:0] addr;
wire addr_ok;
wire [4:0] opcode;
wire start_ok;
wire start_req;
wire count_end;
reg [31:0] rdata_mux;
reg finish_evt;

////////////////////////////////////////////////////////////////////////
// Pin synchronisers
pin_sync u_org_sync (
	.core_clk(core_clk),
	.resetn(resetn),
	.pin_in(origin_sensor),
	.level_r(org_lvl)
);

pin_sync u_ez_sync (
	.core_clk(core_clk),
	.resetn(resetn),
	.pin_in(encoder_zero_pulse),
	.level_r(ez_lvl)
);

// Edge detection on filtered levels only
assign org_rise = org_lvl & ~org_d_r;
assign org_fall = ~org_lvl & org_d_r;
assign ez_rise = ez_lvl & ~ez_d_r;

////////////////////////////////////////////////////////////////////////
// APB decode, takes effect on the edge that samples pready high
assign bus_take = psel & penable & pready;
assign wr_take = bus_take & pwrite;
assign addr = paddr[`ADDR_W-1:0];
assign addr_ok = (paddr[31:`ADDR_W] == 24'h000000) &&
	((addr == `ADDR_ENV_CFG) || (addr == `ADDR_COMMAND) || (addr == `ADDR_STATUS));

// Environment fields
assign method = env_r[`METHOD_MSB:`METHOD_LSB];
assign zcount_target = env_r[`ZCOUNT_MSB:`ZCOUNT_LSB];

// Start command decode; unsupported methods are refused
assign opcode = pwdata[`OPCODE_MSB:0];
assign start_ok = (method <= `METHOD_5) && (state_r == ST_IDLE);
assign start_req = wr_take && (addr == `ADDR_COMMAND) && paddr[31:`ADDR_W] == 24'h000000 &&
	((opcode == `OP_RETURN_POS) || (opcode == `OP_RETURN_NEG));

// Field holds count minus one, so match ends the count
assign count_end = ez_rise && (zcnt_r == zcount_target);

////////////////////////////////////////////////////////////////////////
// Read data selection; environment register reads as zero
always @* begin
	rdata_mux = 32'h00000000;
	if (addr == `ADDR_STATUS) begin
		rdata_mux[`ST_BUSY_BIT] = (state_r != ST_IDLE);
		rdata_mux[`ST_DONE_BIT] = done_r;
		rdata_mux[`ST_BADCMD_BIT] = bad_cmd_r;
		rdata_mux[`ST_DIR_BIT] = drive_dir_r;
		rdata_mux[`ST_ORG_BIT] = org_lvl;
		rdata_mux[`ST_EZ_BIT] = ez_lvl;
		rdata_mux[`ST_STATE_MSB:`ST_STATE_LSB] = state_r;
		rdata_mux[`ST_ZCNT_MSB:`ST_ZCNT_LSB] = zcnt_r;
	end
end

////////////////////////////////////////////////////////////////////////
// APB slave: one wait state, error on unmapped address
always @(posedge core_clk or negedge resetn) begin
	if (!resetn) begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h00000000;
		env_r <= `ENV_RESET;
	end else begin
		pready <= psel & penable & ~pready;
		pslverr <= psel & penable & ~pready & ~addr_ok;
		if (psel & penable & ~pready) begin
			prdata <= addr_ok ? rdata_mux : 32'h00000000;
		end
		// Method changes while running would corrupt the sequence
		if (wr_take && addr_ok && (addr == `ADDR_ENV_CFG) && (state_r == ST_IDLE)) begin
			env_r <= pwdata[`ZCOUNT_MSB:`METHOD_LSB];
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Sticky flags: hardware set wins over software clear
always @(posedge core_clk or negedge resetn) begin
	if (!resetn) begin
		done_r <= 1'b0;
		bad_cmd_r <= 1'b0;
	end else begin
		if (wr_take && addr_ok && (addr == `ADDR_STATUS)) begin
			if (pwdata[`ST_DONE_BIT]) begin
				done_r <= 1'b0;
			end
			if (pwdata[`ST_BADCMD_BIT]) begin
				bad_cmd_r <= 1'b0;
			end
		end
		if (finish_evt) begin
			done_r <= 1'b1;
		end
		if (start_req && !start_ok) begin
			bad_cmd_r <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Completion event seen by the flag logic
always @* begin
	finish_evt = 1'b0;
	case (state_r)
		ST_FEED: finish_evt = org_rise && (method == `METHOD_0) && !high_speed_r;
		ST_SEARCH: finish_evt = org_rise;
		ST_COUNT: finish_evt = count_end &&
			!(high_speed_r && ((method == `METHOD_3) || (method == `METHOD_5)));
		ST_FINAL: finish_evt = ramp_stopped;
		default: finish_evt = 1'b0;
	endcase
end

////////////////////////////////////////////////////////////////////////
// Origin return sequence
always @(posedge core_clk or negedge resetn) begin
	if (!resetn) begin
		state_r <= ST_IDLE;
		high_speed_r <= 1'b0;
		start_dir_r <= 1'b0;
		zcnt_r <= 4'h0;
		org_d_r <= 1'b0;
		ez_d_r <= 1'b0;
		drive_run_r <= 1'b0;
		drive_dir_r <= 1'b0;
		speed_sel_r <= `SPEED_CONST;
		decel_r <= 1'b0;
		counter_clear_r <= 1'b0;
	end else begin
		org_d_r <= org_lvl;
		ez_d_r <= ez_lvl;
		counter_clear_r <= 1'b0;
		case (state_r)
			ST_IDLE: begin
				// Feed until the completion condition is met
				if (start_req && start_ok) begin
					high_speed_r <= pwdata[`CMD_HIGH_SPEED_BIT];
					start_dir_r <= (opcode == `OP_RETURN_NEG);
					drive_dir_r <= (opcode == `OP_RETURN_NEG);
					speed_sel_r <= pwdata[`CMD_HIGH_SPEED_BIT] ? `SPEED_HIGH : `SPEED_CONST;
					drive_run_r <= 1'b1;
					decel_r <= 1'b0;
					zcnt_r <= 4'h0;
					state_r <= ST_FEED;
				end
			end
			ST_FEED: begin
				if (org_rise) begin
					zcnt_r <= 4'h0;
					case (method)
						`METHOD_0: begin
							counter_clear_r <= 1'b1;
							if (high_speed_r) begin
								decel_r <= 1'b1;
								state_r <= ST_FINAL;
							end else begin
								drive_run_r <= 1'b0;
								state_r <= ST_IDLE;
							end
						end
						`METHOD_2: begin
							// High speed ramps down while counting
							decel_r <= high_speed_r;
							state_r <= ST_COUNT;
						end
						`METHOD_3: begin
							state_r <= ST_COUNT;
						end
						default: begin
							// Methods 1, 4, 5 stop before reversing
							if (high_speed_r) begin
								decel_r <= 1'b1;
							end else begin
								drive_run_r <= 1'b0;
							end
							state_r <= ST_HALT;
						end
					endcase
				end
			end
			ST_HALT: begin
				// Wait for the drive to report standstill
				if (ramp_stopped) begin
					decel_r <= 1'b0;
					drive_run_r <= 1'b1;
					drive_dir_r <= ~start_dir_r;
					if (method == `METHOD_4) begin
						speed_sel_r <= `SPEED_SEARCH;
					end else if (method == `METHOD_5) begin
						speed_sel_r <= high_speed_r ? `SPEED_HIGH : `SPEED_CONST;
					end else begin
						speed_sel_r <= `SPEED_CONST;
					end
					state_r <= ST_REV;
				end
			end
			ST_REV: begin
				if (org_fall) begin
					if (method == `METHOD_1) begin
						drive_dir_r <= start_dir_r;
						speed_sel_r <= `SPEED_SEARCH;
						state_r <= ST_SEARCH;
					end else begin
						zcnt_r <= 4'h0;
						state_r <= ST_COUNT;
					end
				end
			end
			ST_SEARCH: begin
				if (org_rise) begin
					drive_run_r <= 1'b0;
					counter_clear_r <= 1'b1;
					state_r <= ST_IDLE;
				end
			end
			ST_COUNT: begin
				if (count_end) begin
					counter_clear_r <= 1'b1;
					if (high_speed_r && ((method == `METHOD_3) || (method == `METHOD_5))) begin
						decel_r <= 1'b1;
						state_r <= ST_FINAL;
					end else begin
						drive_run_r <= 1'b0;
						decel_r <= 1'b0;
						state_r <= ST_IDLE;
					end
				end else if (ez_rise) begin
					zcnt_r <= zcnt_r + 4'h1;
				end
			end
			ST_FINAL: begin
				// Deceleration stop ends when the ramp reaches rest
				if (ramp_stopped) begin
					decel_r <= 1'b0;
					drive_run_r <= 1'b0;
					state_r <= ST_IDLE;
				end
			end
			default: begin
				state_r <= ST_IDLE;
				drive_run_r <= 1'b0;
				decel_r <= 1'b0;
			end
		endcase
	end
end

endmodule // origin_return_sequencer

// ==== hdl/pin_sync.v ====
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input asynchronous to core_clk
// Notes: Output changes only when stages two and three agree
`timescale 1ns/1ps

module pin_sync (
	input wire core_clk,
	input wire resetn,
	input wire pin_in,
	output reg level_r
);

reg s1_r;
reg s2_r;
reg s3_r;

////////////////////////////////////////////////////////////////////////
// First stage feeds only the second
always @(posedge core_clk or negedge resetn) begin
	if (!resetn) begin
		s1_r <= 1'b0;
		s2_r <= 1'b0;
		s3_r <= 1'b0;
		level_r <= 1'b0;
	end else begin
		s1_r <= pin_in;
		s2_r <= s1_r;
		s3_r <= s2_r;
		// Accept a change once two later stages agree
		if (s2_r == s3_r) begin
			level_r <= s3_r;
		end
	end
end

endmodule // pin_sync

// ==== shared/origin_return_defs.vh ====
// Purpose: Constants for the origin return sequencer
// Assumes: APB byte addresses, 32-bit data
// Notes: Definitions only
`ifndef ORIGIN_RETURN_DEFS_VH
`define ORIGIN_RETURN_DEFS_VH

// Register byte offsets
`define ADDR_ENV_CFG 8'h00
`define ADDR_COMMAND 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_W 8

// Environment register fields
`define METHOD_LSB 0
`define METHOD_MSB 3
`define ZCOUNT_LSB 4
`define ZCOUNT_MSB 7
`define ENV_RESET 8'h00

// Command register fields
`define OPCODE_MSB 4
`define CMD_HIGH_SPEED_BIT 8
`define OP_RETURN_POS 5'h10
`define OP_RETURN_NEG 5'h18

// Status register fields
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 1
`define ST_BADCMD_BIT 2
`define ST_DIR_BIT 3
`define ST_ORG_BIT 4
`define ST_EZ_BIT 5
`define ST_STATE_LSB 8
`define ST_STATE_MSB 10
`define ST_ZCNT_LSB 12
`define ST_ZCNT_MSB 15

// Method codes
`define METHOD_0 4'h0
`define METHOD_1 4'h1
`define METHOD_2 4'h2
`define METHOD_3 4'h3
`define METHOD_4 4'h4
`define METHOD_5 4'h5

// Speed selection on the drive side
`define SPEED_CONST 2'h0
`define SPEED_HIGH 2'h1
`define SPEED_SEARCH 2'h2

`endif

// ==== sim/axis_partner.sv ====
// Purpose: Axis, origin sensor and zero pulse model
// Assumes: Origin spans 100 to 160, zero pulse every 16 steps
// Notes: rewind parks the axis at 0
`timescale 1ns/1ps
module axis_partner (
	input wire core_clk,
	input wire rewind,
	input wire drive_run_r,
	input wire drive_dir_r,
	input wire decel_r,
	input wire counter_clear_r,
	output logic origin_sensor,
	output logic encoder_zero_pulse,
	output logic ramp_stopped,
	output int pos,
	output int clr_pos,
	output int clr_cnt
);
	int tick;
	int ramp;
	////////////////////////////////////////
	// Sensors follow position; ramp ends eight clocks into a decel
	assign origin_sensor = pos >= 100 && pos <= 160;
	assign encoder_zero_pulse = pos % 16 == 0;
	assign ramp_stopped = !drive_run_r || ramp >= 8;
	// Slow stepping keeps each level wide enough for the input filter
	always @(posedge core_clk) begin
		tick <= (tick + 1) % 4;
		ramp <= decel_r ? ramp + 1 : 0;
		if (rewind) begin
			pos <= 0;
			clr_cnt <= 0;
		end else if (drive_run_r && tick == 3)
			pos <= drive_dir_r ? pos - 1 : pos + 1;
		if (counter_clear_r) begin
			clr_pos <= pos;
			clr_cnt <= clr_cnt + 1;
		end
	end
endmodule // axis_partner

// ==== sim/origin_return_sequencer_bench.sv ====
// Purpose: Self-checking bench for origin_return_sequencer
// Assumes: Partner steps once per four clocks
// Notes: Clear position judged within two steps
`timescale 1ns/1ps
`define CHK(s, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR %s expected %0h seen %0h", s, e, g); end end
module origin_return_sequencer_bench;
	logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, rewind = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
	logic pready, pslverr, err, origin_sensor, encoder_zero_pulse, ramp_stopped;
	logic drive_run_r, drive_dir_r, decel_r, counter_clear_r, done_r;
	logic [1:0] speed_sel_r;
	int num_errors = 0, total_checks = 0, pos, clr_pos, clr_cnt, exp_pos, i, m, k, n, dec_seen;
	origin_return_sequencer dut (
		.core_clk(core_clk),
		.resetn(resetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.origin_sensor(origin_sensor),
		.encoder_zero_pulse(encoder_zero_pulse),
		.ramp_stopped(ramp_stopped),
		.drive_run_r(drive_run_r),
		.drive_dir_r(drive_dir_r),
		.speed_sel_r(speed_sel_r),
		.decel_r(decel_r),
		.counter_clear_r(counter_clear_r),
		.done_r(done_r)
	);
	axis_partner p (
		.core_clk(core_clk),
		.rewind(rewind),
		.drive_run_r(drive_run_r),
		.drive_dir_r(drive_dir_r),
		.decel_r(decel_r),
		.counter_clear_r(counter_clear_r),
		.origin_sensor(origin_sensor),
		.encoder_zero_pulse(encoder_zero_pulse),
		.ramp_stopped(ramp_stopped),
		.pos(pos),
		.clr_pos(clr_pos),
		.clr_cnt(clr_cnt)
	);
	////////////////////////////////////////
	initial forever #5 core_clk = ~core_clk;
	// One APB transfer; only the watchdog ends a wait on pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= {24'h00, a};
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task tally_and_finish;
		if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Hang guard, far past the longest run
	initial begin
		repeat (60000) @(posedge core_clk);
		num_errors++;
		tally_and_finish;
	end
	initial begin
		repeat (20) @(posedge core_clk);
		resetn <= 1;
		apb(0, 8'h00, 0);
		`CHK("env read", 32'h0, rd)
		apb(0, 8'h0c, 0);
		`CHK("unmapped", 1'b1, err)
		apb(1, 8'h00, 32'h6);
		apb(1, 8'h04, 32'h10);
		apb(0, 8'h08, 0);
		`CHK("bad method", 2'b10, {rd[2], rd[0]})
		// Every method at constant, then at high speed
		for (i = 0; i < 12; i++) begin
			m = i % 6;
			k = m < 2 ? 0 : m - 2;
			exp_pos = m < 2 ? 100 : m < 4 ? 112 + 16 * k : 96 - 16 * k;
			rewind <= 1;
			apb(1, 8'h00, {k[3:0], m[3:0]});
			rewind <= 0;
			apb(1, 8'h04, {23'h0, i > 5, 8'h10});
			dec_seen = 0;
			for (n = 0; n < 4000 && done_r !== 1'b1; n++) begin
				@(posedge core_clk);
				if (decel_r === 1'b1) begin
					dec_seen = 1;
				end
			end
			apb(0, 8'h08, 0);
			`CHK("done", 1'b1, rd[1])
			`CHK("clears", 1, clr_cnt)
			`CHK("clear pos", 1'b1, clr_pos - exp_pos inside {[-2:2]})
			`CHK("dir", m > 3, drive_dir_r)
			`CHK("run", 1'b0, drive_run_r)
			`CHK("speed", m == 1 || m == 4 ? 2 : i > 5, speed_sel_r)
			`CHK("decel used", i > 5, dec_seen)
			apb(1, 8'h08, 32'h2);
		end
		apb(0, 8'h08, 0);
		`CHK("done clr", 1'b0, rd[1])
		tally_and_finish;
	end
endmodule // origin_return_sequencer_bench

// ==== sim/ors_checker_asserts.sv ====
// Purpose: Port checks for origin_return_sequencer
// Assumes: One clock, async reset resetn
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
module ors_checker (
	input wire core_clk,
	input wire resetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	input wire ramp_stopped,
	input wire drive_run_r,
	input wire drive_dir_r,
	input wire decel_r,
	input wire counter_clear_r,
	input wire done_r
);
	////////////////////////////////////////
	// Status write that clears the done flag
	wire done_clr = psel && penable && pready && pwrite && paddr[7:0] == 8'h08 && pwdata[1];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	pready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
	wait_state_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("wait state wrong");
	slverr_with_a: assert property (pslverr |-> pready) else $error("stray pslverr");
	clear_pulse_a: assert property (counter_clear_r |=> !counter_clear_r)
		else $error("clear too long");
	done_stop_a: assert property ($rose(done_r) |-> !drive_run_r && !decel_r)
		else $error("done while moving");
	decel_run_a: assert property (decel_r |-> drive_run_r)
		else $error("decel without run");
	done_hold_a: assert property (done_r && !done_clr |=> done_r)
		else $error("done lost");
	// A ramp still running means the axis moves: no reversal before rest
	dir_hold_a: assert property (decel_r && !ramp_stopped |=> $stable(drive_dir_r))
		else $error("dir changed during ramp");
	// Main scenarios reached
	cover property ($rose(done_r));
	cover property (decel_r);
	cover property (pslverr);
	cover property (drive_run_r && drive_dir_r);
endmodule // ors_checker
bind origin_return_sequencer ors_checker chk (
	.core_clk(core_clk),
	.resetn(resetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.pready(pready),
	.pslverr(pslverr),
	.ramp_stopped(ramp_stopped),
	.drive_run_r(drive_run_r),
	.drive_dir_r(drive_dir_r),
	.decel_r(decel_r),
	.counter_clear_r(counter_clear_r),
	.done_r(done_r)
);
